// ===== hdl/loopback_regs.svh
/*
  Register offsets, field positions, reset values and timing counts of the
  per-channel loopback and inband code control registers.
  Assumes a host port with an 8-bit address: bits 7-6 channel, bits 5-0 offset.
*/
`ifndef LOOPBACK_REGS_SVH
`define LOOPBACK_REGS_SVH

// register offsets within one channel window
`define LB_OFS_PATTERN 6'h0A
`define LB_OFS_LOOP_CTRL 6'h0B
`define LB_OFS_CODE_LEN 6'h0C
`define LB_OFS_TX_CODE 6'h0D
`define LB_OFS_ACT_CODE 6'h0E
`define LB_OFS_DEACT_CODE 6'h0F
`define LB_OFS_IRQ_MASK 6'h11

// loopback control fields
`define LB_BIT_DIGITAL 0
`define LB_BIT_ANALOG 1
`define LB_BIT_REMOTE 2
`define LB_BIT_AUTO_REMOTE 3
`define LB_LOOP_CTRL_MASK 8'h0F

// code length fields
`define LB_TX_LEN_LSB 4
`define LB_ACT_LEN_LSB 2
`define LB_DEACT_LEN_LSB 0

// pattern select field and interrupt mask bit
`define LB_PATTERN_LSB 5
`define LB_ACT_IRQ_MASK_BIT 6

// reset values
`define LB_RST_PATTERN 8'h00
`define LB_RST_LOOP_CTRL 8'h00
`define LB_RST_CODE_LEN 8'h01
`define LB_RST_TX_CODE 8'h01
`define LB_RST_ACT_CODE 8'h01
`define LB_RST_DEACT_CODE 8'h09
`define LB_RST_IRQ_MASK 8'h40

// matching bits in a row that count as sustained detection
`define LB_DETECT_HOLD_BITS 48

`endif

// ===== hdl/loopback_pkg.sv
/*
  Types shared by the loopback control block and its code detector.
  Assumes loopback_regs.svh supplies the numeric constants.
*/
package loopback_pkg;
  typedef logic [1:0] code_len_t;
  typedef logic [7:0] code_t;
  typedef enum logic [1:0] {
    PATTERN_NORMAL = 2'h0,
    PATTERN_ALL_ONES = 2'h1,
    PATTERN_PRBS = 2'h2,
    PATTERN_INBAND = 2'h3
  } pattern_sel_t;
endpackage

// ===== hdl/code_det_if.sv
/*
  Carrier between the control block and one inband code detector.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
interface code_det_if;
  import loopback_pkg::*;
  logic bit_en;
  logic rx_bit;
  code_t code;
  code_len_t len;
  logic detected;
  modport det(input bit_en, input rx_bit, input code, input len, output detected);
  modport src(output bit_en, output rx_bit, output code, output len, input detected);
endinterface

// ===== hdl/inband_code_detector.sv
/*
  Detects a repeating inband code of 5 to 8 bits in a received bit stream.
  Assumes one bit per bit_en pulse, on the system clock.
*/
`timescale 1ns/1ps
module inband_code_detector #(
  parameter int HOLD_BITS = 48
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // detector carrier
  code_det_if.det det
);
  import loopback_pkg::*;

  localparam int RUN_W = $clog2(HOLD_BITS + 1);
  localparam logic [RUN_W-1:0] RUN_FULL = RUN_W'(HOLD_BITS);

  generate
    if (HOLD_BITS < 8) begin : g_bad_hold
      $error("HOLD_BITS must cover at least one full code");
    end
  endgenerate

  logic [2:0] phase_reg;
  logic [RUN_W-1:0] run_reg;
  logic detected_reg;
  logic [2:0] last_idx;
  logic [2:0] bit_idx;
  logic expected;

  // code is sent msb of the selected length first
  assign last_idx = 3'(det.len) + 3'h4;
  assign bit_idx = last_idx - phase_reg;
  assign expected = det.code[bit_idx];

  // a mismatch restarts the phase so the run realigns on the next bits
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      phase_reg <= 3'h0;
      run_reg <= '0;
    end else if (det.bit_en) begin
      if (det.rx_bit == expected) begin
        phase_reg <= (phase_reg == last_idx) ? 3'h0 : phase_reg + 3'h1;
        if (run_reg != RUN_FULL) begin
          run_reg <= run_reg + RUN_W'(1);
        end
      end else begin
        phase_reg <= 3'h0;
        run_reg <= '0;
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      detected_reg <= 1'b0;
    end else begin
      detected_reg <= (run_reg == RUN_FULL);
    end
  end

  assign det.detected = detected_reg;
endmodule // inband_code_detector

// ===== hdl/loopback_inband_code_control.sv
/*
  Four-channel loopback and inband loopback code control: host registers,
  loopback routing, inband code insertion and automatic remote loopback.
  Assumes line pins arrive asynchronously with a bit strobe per channel and
  the system transmit data comes from logic on i_clk, one bit per line strobe.
*/
`timescale 1ns/1ps
`include "loopback_regs.svh"
module loopback_inband_code_control #(
  parameter int CHANNELS = 4,
  parameter int HOLD_BITS = `LB_DETECT_HOLD_BITS
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // host control port
  input wire logic [7:0] i_addr,
  input wire logic i_wr_en,
  input wire logic i_rd_en,
  input wire loopback_pkg::code_t i_wdata,
  output loopback_pkg::code_t o_rdata,
  // line side pins
  input wire logic [CHANNELS-1:0] i_line_rx_data,
  input wire logic [CHANNELS-1:0] i_line_bit_en,
  output logic [CHANNELS-1:0] o_line_tx_data,
  // system side
  input wire logic [CHANNELS-1:0] i_sys_tx_data,
  output logic [CHANNELS-1:0] o_sys_rx_data,
  output logic [CHANNELS-1:0] o_sys_bit_en,
  // status
  output logic [CHANNELS-1:0] o_remote_loop_active,
  output logic [CHANNELS-1:0] o_activate_irq
);
  import loopback_pkg::*;

  generate
    if (CHANNELS < 1 || CHANNELS > 4) begin : g_bad_chan
      $error("CHANNELS must be 1 to 4 for a 2-bit channel field");
    end
  endgenerate

  function automatic logic reg_hit(input logic [7:0] addr, input int ch,
                                   input logic [5:0] ofs);
    reg_hit = (addr[7:6] == 2'(ch)) && (addr[5:0] == ofs);
  endfunction

  function automatic logic [2:0] code_last_idx(input code_len_t len);
    code_last_idx = 3'(len) + 3'h4;
  endfunction

  // per-channel register storage
  logic [3:0] loop_ctrl_reg [CHANNELS];
  logic [5:0] code_len_reg [CHANNELS];
  code_t tx_code_reg [CHANNELS];
  code_t act_code_reg [CHANNELS];
  code_t deact_code_reg [CHANNELS];
  pattern_sel_t pattern_reg [CHANNELS];
  logic act_mask_reg [CHANNELS];
  code_t rdata_reg;

  // pin synchronisers and bit strobe edge
  logic [CHANNELS-1:0] rx_sync1_reg;
  logic [CHANNELS-1:0] rx_sync2_reg;
  logic [CHANNELS-1:0] en_sync1_reg;
  logic [CHANNELS-1:0] en_sync2_reg;
  logic [CHANNELS-1:0] en_sync3_reg;
  logic [CHANNELS-1:0] bit_strobe;

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      rx_sync1_reg <= '0;
      rx_sync2_reg <= '0;
      en_sync1_reg <= '0;
      en_sync2_reg <= '0;
      en_sync3_reg <= '0;
    end else begin
      rx_sync1_reg <= i_line_rx_data;
      rx_sync2_reg <= rx_sync1_reg;
      en_sync1_reg <= i_line_bit_en;
      en_sync2_reg <= en_sync1_reg;
      en_sync3_reg <= en_sync2_reg;
    end
  end

  assign bit_strobe = en_sync2_reg & ~en_sync3_reg;

  // host writes
  genvar gc;
  generate
    for (gc = 0; gc < CHANNELS; gc++) begin : g_regs
      always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
          loop_ctrl_reg[gc] <= 4'(`LB_RST_LOOP_CTRL);
          code_len_reg[gc] <= 6'(`LB_RST_CODE_LEN);
          tx_code_reg[gc] <= `LB_RST_TX_CODE;
          act_code_reg[gc] <= `LB_RST_ACT_CODE;
          deact_code_reg[gc] <= `LB_RST_DEACT_CODE;
          pattern_reg[gc] <= PATTERN_NORMAL;
          act_mask_reg[gc] <= 1'(`LB_RST_IRQ_MASK >> `LB_ACT_IRQ_MASK_BIT);
        end else if (i_wr_en) begin
          if (reg_hit(i_addr, gc, `LB_OFS_LOOP_CTRL)) begin
            loop_ctrl_reg[gc] <= i_wdata[3:0];
          end
          if (reg_hit(i_addr, gc, `LB_OFS_CODE_LEN)) begin
            code_len_reg[gc] <= i_wdata[5:0];
          end
          if (reg_hit(i_addr, gc, `LB_OFS_TX_CODE)) begin
            tx_code_reg[gc] <= i_wdata;
          end
          if (reg_hit(i_addr, gc, `LB_OFS_ACT_CODE)) begin
            act_code_reg[gc] <= i_wdata;
          end
          if (reg_hit(i_addr, gc, `LB_OFS_DEACT_CODE)) begin
            deact_code_reg[gc] <= i_wdata;
          end
          if (reg_hit(i_addr, gc, `LB_OFS_PATTERN)) begin
            pattern_reg[gc] <= pattern_sel_t'(i_wdata[`LB_PATTERN_LSB +: 2]);
          end
          if (reg_hit(i_addr, gc, `LB_OFS_IRQ_MASK)) begin
            act_mask_reg[gc] <= i_wdata[`LB_ACT_IRQ_MASK_BIT];
          end
        end
      end
    end
  endgenerate

  // host reads, registered; unmapped offsets read zero
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      rdata_reg <= 8'h00;
    end else if (i_rd_en) begin
      rdata_reg <= 8'h00;
      for (int c = 0; c < CHANNELS; c++) begin
        if (reg_hit(i_addr, c, `LB_OFS_LOOP_CTRL)) begin
          rdata_reg <= {4'h0, loop_ctrl_reg[c]};
        end
        if (reg_hit(i_addr, c, `LB_OFS_CODE_LEN)) begin
          rdata_reg <= {2'h0, code_len_reg[c]};
        end
        if (reg_hit(i_addr, c, `LB_OFS_TX_CODE)) begin
          rdata_reg <= tx_code_reg[c];
        end
        if (reg_hit(i_addr, c, `LB_OFS_ACT_CODE)) begin
          rdata_reg <= act_code_reg[c];
        end
        if (reg_hit(i_addr, c, `LB_OFS_DEACT_CODE)) begin
          rdata_reg <= deact_code_reg[c];
        end
        if (reg_hit(i_addr, c, `LB_OFS_PATTERN)) begin
          rdata_reg <= {1'h0, pattern_reg[c], 5'h00};
        end
        if (reg_hit(i_addr, c, `LB_OFS_IRQ_MASK)) begin
          rdata_reg <= {1'h0, act_mask_reg[c], 6'h00};
        end
      end
    end
  end

  assign o_rdata = rdata_reg;

  // per-channel datapath
  logic [CHANNELS-1:0] line_tx_reg;
  logic [CHANNELS-1:0] sys_rx_reg;
  logic [CHANNELS-1:0] sys_bit_en_reg;
  logic [CHANNELS-1:0] auto_loop_reg;
  logic [CHANNELS-1:0] remote_reg;
  logic [CHANNELS-1:0] irq_reg;

  generate
    for (gc = 0; gc < CHANNELS; gc++) begin : g_chan
      code_det_if act_if();
      code_det_if deact_if();
      logic [2:0] tx_phase_reg;
      logic [2:0] tx_last;
      logic tx_code_bit;
      logic line_rx_eff;
      logic remote_on;
      logic dig_on;
      logic ana_on;
      logic auto_on;

      assign dig_on = loop_ctrl_reg[gc][`LB_BIT_DIGITAL];
      assign ana_on = loop_ctrl_reg[gc][`LB_BIT_ANALOG];
      assign auto_on = loop_ctrl_reg[gc][`LB_BIT_AUTO_REMOTE];
      assign remote_on = loop_ctrl_reg[gc][`LB_BIT_REMOTE] | auto_loop_reg[gc];
      assign line_rx_eff = ana_on ? line_tx_reg[gc] : rx_sync2_reg[gc];

      // transmit code generator, msb of selected length first
      assign tx_last = code_last_idx(code_len_reg[gc][`LB_TX_LEN_LSB +: 2]);
      assign tx_code_bit = tx_code_reg[gc][3'(tx_last - tx_phase_reg)];

      always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
          tx_phase_reg <= 3'h0;
        end else if (pattern_reg[gc] != PATTERN_INBAND) begin
          tx_phase_reg <= 3'h0;
        end else if (bit_strobe[gc]) begin
          tx_phase_reg <= (tx_phase_reg >= tx_last) ? 3'h0 : tx_phase_reg + 3'h1;
        end
      end

      // line transmit: remote loop wins over pattern insertion
      always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
          line_tx_reg[gc] <= 1'b0;
        end else if (bit_strobe[gc]) begin
          if (remote_on) begin
            line_tx_reg[gc] <= rx_sync2_reg[gc];
          end else if (pattern_reg[gc] == PATTERN_INBAND) begin
            line_tx_reg[gc] <= tx_code_bit;
          end else begin
            line_tx_reg[gc] <= i_sys_tx_data[gc];
          end
        end
      end

      // system receive
      always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
          sys_rx_reg[gc] <= 1'b0;
          sys_bit_en_reg[gc] <= 1'b0;
        end else begin
          sys_bit_en_reg[gc] <= bit_strobe[gc];
          if (bit_strobe[gc]) begin
            sys_rx_reg[gc] <= dig_on ? i_sys_tx_data[gc] : line_rx_eff;
          end
        end
      end

      // inband code detectors on the received line data
      assign act_if.bit_en = bit_strobe[gc];
      assign act_if.rx_bit = line_rx_eff;
      assign act_if.code = act_code_reg[gc];
      assign act_if.len = code_len_reg[gc][`LB_ACT_LEN_LSB +: 2];
      assign deact_if.bit_en = bit_strobe[gc];
      assign deact_if.rx_bit = line_rx_eff;
      assign deact_if.code = deact_code_reg[gc];
      assign deact_if.len = code_len_reg[gc][`LB_DEACT_LEN_LSB +: 2];

      inband_code_detector #(
        .HOLD_BITS(HOLD_BITS)
      ) u_act_det (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .det(act_if)
      );

      inband_code_detector #(
        .HOLD_BITS(HOLD_BITS)
      ) u_deact_det (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .det(deact_if)
      );

      // automatic remote loop; deactivate wins if both codes are seen
      always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
          auto_loop_reg[gc] <= 1'b0;
        end else if (!auto_on) begin
          auto_loop_reg[gc] <= 1'b0;
        end else if (deact_if.detected) begin
          auto_loop_reg[gc] <= 1'b0;
        end else if (act_if.detected) begin
          auto_loop_reg[gc] <= 1'b1;
        end
      end

      always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
          remote_reg[gc] <= 1'b0;
          irq_reg[gc] <= 1'b0;
        end else begin
          remote_reg[gc] <= remote_on;
          irq_reg[gc] <= act_if.detected & ~act_mask_reg[gc];
        end
      end
    end
  endgenerate

  assign o_line_tx_data = line_tx_reg;
  assign o_sys_rx_data = sys_rx_reg;
  assign o_sys_bit_en = sys_bit_en_reg;
  assign o_remote_loop_active = remote_reg;
  assign o_activate_irq = irq_reg;
endmodule // loopback_inband_code_control

// ===== testbench/lbc_sva.sv
/*
  Port checks of the loopback control block.
  Assumes channel 0 is representative of all channels.
*/
`timescale 1ns/1ps
module lbc_sva #(
  parameter int CHANNELS = 4,
  parameter int HOLD_BITS = 48
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic [7:0] i_addr,
  input wire logic i_wr_en,
  input wire logic i_rd_en,
  input wire loopback_pkg::code_t i_wdata,
  input wire loopback_pkg::code_t o_rdata,
  input wire logic [CHANNELS-1:0] i_sys_tx_data,
  input wire logic [CHANNELS-1:0] o_line_tx_data,
  input wire logic [CHANNELS-1:0] o_sys_rx_data,
  input wire logic [CHANNELS-1:0] o_sys_bit_en,
  input wire logic [CHANNELS-1:0] o_remote_loop_active,
  input wire logic [CHANNELS-1:0] o_activate_irq
);
  import loopback_pkg::*;
  logic [3:0] ctl_reg;
  logic mask_reg;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  // shadow of channel 0 settings
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) ctl_reg <= 4'h0;
    else if (i_wr_en && i_addr == 8'h0B) ctl_reg <= i_wdata[3:0];
  end
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) mask_reg <= 1'b1;
    else if (i_wr_en && i_addr == 8'h11) mask_reg <= i_wdata[6];
  end
  sequence s_ctl_write;
    i_wr_en && i_addr[5:0] == 6'h0B;
  endsequence
  sequence s_same_read;
    i_rd_en && !i_wr_en && i_addr == $past(i_addr);
  endsequence
  a_ctl_readback: assert property (
    s_ctl_write ##1 s_same_read |=> o_rdata == ($past(i_wdata, 2) & 8'h0F))
    else $error("loop control readback wrong");
  a_unmapped_zero: assert property (
    i_rd_en && !(i_addr[5:0] inside {[6'h0A:6'h0F], 6'h11}) |=> o_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_ctl_reserved: assert property (
    i_rd_en && i_addr[5:0] == 6'h0B |=> o_rdata[7:4] == 4'h0)
    else $error("loop control reserved bits set");
  a_len_reserved: assert property (
    i_rd_en && i_addr[5:0] == 6'h0C |=> o_rdata[7:6] == 2'h0)
    else $error("length reserved bits set");
  a_rdata_holds: assert property (!i_rd_en |=> $stable(o_rdata))
    else $error("read data moved");
  a_digital_loop: assert property (
    o_sys_bit_en[0] && ctl_reg[0] |-> o_sys_rx_data[0] == $past(i_sys_tx_data[0]))
    else $error("digital loop data wrong");
  a_remote_echo: assert property (
    o_sys_bit_en[0] && ctl_reg == 4'h4 |-> o_line_tx_data[0] == o_sys_rx_data[0])
    else $error("remote loop data wrong");
  a_manual_remote: assert property (ctl_reg[2] [*2] |-> o_remote_loop_active[0])
    else $error("remote loop not active");
  a_auto_off: assert property (
    (ctl_reg[3:2] == 2'h0) [*3] |-> !o_remote_loop_active[0])
    else $error("remote loop active while disabled");
  a_irq_masked: assert property (mask_reg [*2] |-> !o_activate_irq[0])
    else $error("masked interrupt raised");
endmodule // lbc_sva

bind loopback_inband_code_control lbc_sva #(.CHANNELS(CHANNELS), .HOLD_BITS(HOLD_BITS)) u_sva (
  .i_clk(i_clk),
  .i_sys_rst(i_sys_rst),
  .i_addr(i_addr),
  .i_wr_en(i_wr_en),
  .i_rd_en(i_rd_en),
  .i_wdata(i_wdata),
  .o_rdata(o_rdata),
  .i_sys_tx_data(i_sys_tx_data),
  .o_line_tx_data(o_line_tx_data),
  .o_sys_rx_data(o_sys_rx_data),
  .o_sys_bit_en(o_sys_bit_en),
  .o_remote_loop_active(o_remote_loop_active),
  .o_activate_irq(o_activate_irq)
);

// ===== testbench/line_term_model.sv
/*
  Remote line terminal: repeats a code on all line pins with a bit strobe.
  Assumes the device syncs both pins to its own clock.
*/
`timescale 1ns/1ps
module line_term_model (
  // control
  input wire logic i_clk,
  input wire logic i_go,
  input wire logic [7:0] i_bits,
  input wire loopback_pkg::code_t i_code,
  input wire loopback_pkg::code_len_t i_len,
  // line pins
  output logic [3:0] o_rx_data,
  output logic [3:0] o_bit_en,
  output logic o_busy
);
  import loopback_pkg::*;
  initial begin
    o_rx_data = 4'h0;
    o_bit_en = 4'h0;
    o_busy = 1'b0;
    forever begin
      @(posedge i_clk iff i_go);
      #1;
      o_busy = 1'b1;
      for (int b = 0; b < i_bits; b++) begin
        // high bit of the selected length first
        o_rx_data = {4{i_code[i_len + 4 - b % (i_len + 5)]}};
        repeat (2) @(posedge i_clk);
        #1;
        o_bit_en = 4'hF;
        repeat (3) @(posedge i_clk);
        #1;
        o_bit_en = 4'h0;
        // data is not held once the strobe falls
        o_rx_data = ~o_rx_data;
        repeat (3) @(posedge i_clk);
        #1;
      end
      o_busy = 1'b0;
    end
  end
endmodule // line_term_model

// ===== testbench/test_loopback_inband_code_control.sv
/*
  Self-checking bench of the loopback control block.
  Assumes the line model drives all four channels alike.
*/
`timescale 1ns/1ps
module test_loopback_inband_code_control;
  import loopback_pkg::*;
  logic i_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic [7:0] i_addr = 8'h00;
  logic i_wr_en = 1'b0;
  logic i_rd_en = 1'b0;
  code_t i_wdata = 8'h00;
  logic [3:0] i_sys_tx_data = 4'h0;
  code_t o_rdata;
  logic [3:0] i_line_rx_data, i_line_bit_en, o_line_tx_data, o_sys_rx_data;
  logic [3:0] o_sys_bit_en, o_remote_loop_active, o_activate_irq;
  code_t rc = 8'h01;
  code_t tc = 8'h01;
  code_len_t rl = 2'h0;
  code_len_t tl = 2'h0;
  logic [7:0] p_bits = 8'h00;
  logic p_go = 1'b0;
  logic p_busy;
  logic [3:0] lb = 4'h0;
  logic code_on = 1'b0;
  logic rd_d = 1'b0;
  code_t rd_q[$];
  logic [7:0] bit_q[$];
  int errors = 0;
  int num_checks = 0;
  localparam logic [5:0] OFS [7] = '{6'h0A, 6'h0B, 6'h0C, 6'h0D, 6'h0E, 6'h0F, 6'h11};
  localparam code_t RST [7] = '{8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h09, 8'h40};
  localparam code_t MSK [7] = '{8'h60, 8'h0F, 8'h3F, 8'hFF, 8'hFF, 8'hFF, 8'h40};
  localparam logic [3:0] LBM [5] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h5};
  always #20 i_clk = ~i_clk;
  loopback_inband_code_control #(.HOLD_BITS(8)) dut (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_addr(i_addr),
    .i_wr_en(i_wr_en),
    .i_rd_en(i_rd_en),
    .i_wdata(i_wdata),
    .o_rdata(o_rdata),
    .i_line_rx_data(i_line_rx_data),
    .i_line_bit_en(i_line_bit_en),
    .o_line_tx_data(o_line_tx_data),
    .i_sys_tx_data(i_sys_tx_data),
    .o_sys_rx_data(o_sys_rx_data),
    .o_sys_bit_en(o_sys_bit_en),
    .o_remote_loop_active(o_remote_loop_active),
    .o_activate_irq(o_activate_irq)
  );
  line_term_model far_end (
    .i_clk(i_clk),
    .i_go(p_go),
    .i_bits(p_bits),
    .i_code(rc),
    .i_len(rl),
    .o_rx_data(i_line_rx_data),
    .o_bit_en(i_line_bit_en),
    .o_busy(p_busy)
  );
  task automatic report(string what, logic [7:0] e, logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic check_rd(code_t e);
    report("o_rdata", e, o_rdata);
  endtask
  task automatic check_bits(logic [7:0] e);
    report("line_tx_sys_rx", e, {o_line_tx_data, o_sys_rx_data});
  endtask
  task automatic check_st(logic [7:0] e);
    report("loop_irq", e, {o_remote_loop_active, o_activate_irq});
  endtask
  always @(posedge i_clk) rd_d <= i_rd_en;
  always @(negedge i_clk) begin
    if (rd_d && rd_q.size() > 0) check_rd(rd_q.pop_front());
    if (o_sys_bit_en[0] === 1'b1 && bit_q.size() > 0) check_bits(bit_q.pop_front());
  end
  task automatic wr(logic [7:0] a, code_t d);
    i_addr = a;
    i_wdata = d;
    i_wr_en = 1'b1;
    i_rd_en = 1'b0;
    @(negedge i_clk);
  endtask
  task automatic rd(logic [7:0] a, code_t e);
    i_addr = a;
    i_rd_en = 1'b1;
    i_wr_en = 1'b0;
    rd_q.push_back(e);
    @(negedge i_clk);
  endtask
  task automatic idle();
    i_wr_en = 1'b0;
    i_rd_en = 1'b0;
    @(negedge i_clk);
  endtask
  task automatic wr_all(logic [5:0] o, code_t d);
    for (int c = 0; c < 4; c++) wr({c[1:0], o}, d);
    idle();
  endtask
  task automatic send(code_t c, code_len_t l, logic [7:0] n);
    rc = c;
    rl = l;
    p_bits = n;
    p_go = 1'b1;
    @(posedge p_busy);
    p_go = 1'b0;
    wait (p_busy === 1'b0);
    @(negedge i_clk);
  endtask
  function automatic logic [7:0] exp_bits(int b);
    logic rb;
    logic cb;
    logic [3:0] ln;
    rb = rc[rl + 4 - b % (rl + 5)];
    cb = tc[tl + 4 - b % (tl + 5)];
    ln = lb[2] ? {4{rb}} : (code_on ? {4{cb}} : i_sys_tx_data);
    return {ln, lb[0] ? i_sys_tx_data : (lb[1] ? ln : {4{rb}})};
  endfunction
  task automatic stream(int warm, int n);
    if (warm > 0) send(rc, rl, 8'(warm));
    for (int b = 0; b < n; b++) bit_q.push_back(exp_bits(b));
    send(rc, rl, 8'(n));
  endtask
  task automatic tally_and_finish();
    if (errors == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #2000000;
    errors++;
    tally_and_finish();
  end
  initial begin
    code_t d;
    void'($urandom(32'h648d72f3));
    repeat (12) @(negedge i_clk);
    i_sys_rst = 1'b0;
    @(negedge i_clk);
    for (int c = 0; c < 4; c++)
      for (int r = 0; r < 7; r++) rd({c[1:0], OFS[r]}, RST[r]);
    for (int c = 0; c < 4; c++)
      for (int r = 0; r < 7; r++) begin
        d = 8'($urandom());
        wr({c[1:0], OFS[r]}, d);
        rd({c[1:0], OFS[r]}, d & MSK[r]);
      end
    rd(8'h3F, 8'h00);
    rd(8'hA0, 8'h00);
    idle();
    i_sys_rst = 1'b1;
    repeat (3) @(negedge i_clk);
    i_sys_rst = 1'b0;
    @(negedge i_clk);
    wr_all(6'h11, 8'h00);
    send(8'h01, 2'h0, 8'h28);
    check_st(8'h0F);
    wr_all(6'h0B, 8'h08);
    send(8'h01, 2'h0, 8'h28);
    check_st(8'hFF);
    send(8'h09, 2'h1, 8'h28);
    check_st(8'h00);
    wr_all(6'h11, 8'h40);
    send(8'h01, 2'h0, 8'h28);
    check_st(8'hF0);
    wr_all(6'h0B, 8'h00);
    idle();
    check_st(8'h00);
    foreach (LBM[k]) begin
      lb = LBM[k];
      i_sys_tx_data = 4'($urandom());
      wr_all(6'h0B, {4'h0, lb});
      rc = 8'($urandom());
      rl = 2'($urandom());
      stream(2, 12);
    end
    lb = 4'h0;
    wr_all(6'h0B, 8'h00);
    for (int l = 0; l < 4; l++) begin
      tl = 2'(l);
      tc = 8'($urandom());
      wr_all(6'h0A, 8'h00);
      wr_all(6'h0C, {2'h0, tl, 4'h0});
      wr_all(6'h0D, tc);
      wr_all(6'h0A, 8'h60);
      code_on = 1'b1;
      stream(0, 2 * l + 11);
      code_on = 1'b0;
    end
    tally_and_finish();
  end
endmodule // test_loopback_inband_code_control
